// ==== core/lvds_serializer_transmitter.sv ====
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps

module ser_tx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic empty,
	output logic full
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	logic push;
	logic pop;

	assign full = (count_ff == (AW+1)'(DEPTH));
	assign empty = (count_ff == '0);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_ptr_ff];
	assign push = in_valid && !full;
	assign pop = out_ready && !empty;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module lvds_serializer_transmitter #(
	parameter int CHANNELS = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tx_pll_enable,
	input wire logic [CHANNELS*ser_tx_pkg::J_MAX-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [CHANNELS-1:0] ser_out,
	output logic fwd_clk,
	output logic core_clk,
	output logic ref_clk,
	output logic tx_locked
);
	localparam int JM = ser_tx_pkg::J_MAX;
	localparam int BUS_W = CHANNELS * JM;

	ser_tx_pkg::cfg_t cfg_ff;
	ser_tx_pkg::cfg_t wr_cfg;
	logic [ser_tx_pkg::REFK_W-1:0] refk_ff;
	logic cfg_err_ff;
	logic underrun_ff;
	logic running_ff;
	logic [3:0] bitcnt_ff;
	logic half_ff;
	logic [4:0] fwdcnt_ff;
	logic [4:0] refcnt_ff;
	logic [4:0] fstart;
	logic [4:0] rstart;
	logic [7:0] foff;
	logic [7:0] roff;
	logic boundary;
	logic bit_start;
	logic wr_en;
	logic rd_setup;
	logic mapped;
	logic [31:0] rd_val;
	logic [BUS_W-1:0] stg_ff;
	logic stg_vld_ff;
	logic reg_tick;
	logic [BUS_W-1:0] f_in_data;
	logic f_in_valid;
	logic f_in_ready;
	logic [BUS_W-1:0] f_out_data;
	logic f_out_valid;
	logic f_empty;
	logic f_full;
	logic [JM-1:0] lane_word [CHANNELS];
	logic [JM-1:0] shreg_ff [CHANNELS];

	// register bus: zero wait, read data captured in setup phase
	assign pready = 1'b1;
	assign mapped = (paddr == ser_tx_pkg::ADDR_CFG) || (paddr == ser_tx_pkg::ADDR_REFK)
		|| (paddr == ser_tx_pkg::ADDR_STATUS);
	assign pslverr = psel && penable && !mapped;
	assign wr_en = psel && penable && pwrite && mapped;
	assign rd_setup = psel && !penable && !pwrite;
	assign wr_cfg = ser_tx_pkg::cfg_resolve(ser_tx_pkg::cfg_t'(pwdata[ser_tx_pkg::CFG_W-1:0]));

	always_comb begin
		rd_val = '0;
		unique case (paddr)
			ser_tx_pkg::ADDR_CFG: rd_val = 32'(cfg_ff);
			ser_tx_pkg::ADDR_REFK: rd_val = 32'(refk_ff);
			ser_tx_pkg::ADDR_STATUS: begin
				rd_val[ser_tx_pkg::ST_LOCKED] = running_ff;
				rd_val[ser_tx_pkg::ST_CFG_ERR] = cfg_err_ff;
				rd_val[ser_tx_pkg::ST_UNDERRUN] = underrun_ff;
				rd_val[ser_tx_pkg::ST_EMPTY] = f_empty;
				rd_val[ser_tx_pkg::ST_FULL] = f_full;
			end
			default: rd_val = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (rd_setup) begin
			prdata <= rd_val;
		end
	end

	// new settings are checked as a whole and refused while running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= ser_tx_pkg::CFG_RESET;
			refk_ff <= ser_tx_pkg::REFK_RESET;
			cfg_err_ff <= 1'b0;
		end else if (wr_en && paddr == ser_tx_pkg::ADDR_CFG) begin
			if (!running_ff && ser_tx_pkg::cfg_legal(wr_cfg, refk_ff)) begin
				cfg_ff <= wr_cfg;
				cfg_err_ff <= 1'b0;
			end else begin
				cfg_err_ff <= 1'b1;
			end
		end else if (wr_en && paddr == ser_tx_pkg::ADDR_REFK) begin
			if (!running_ff && ser_tx_pkg::cfg_legal(cfg_ff, pwdata[ser_tx_pkg::REFK_W-1:0])) begin
				refk_ff <= pwdata[ser_tx_pkg::REFK_W-1:0];
				cfg_err_ff <= 1'b0;
			end else begin
				cfg_err_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			running_ff <= 1'b0;
		end else begin
			running_ff <= tx_pll_enable;
		end
	end

	// one bit lasts two pclk cycles so the forwarded and reference clocks have whole half periods
	assign foff = 8'((8'(cfg_ff.out_phase) * 8'(cfg_ff.b)) >> 2);
	assign roff = 8'((8'(cfg_ff.in_phase) * 8'(cfg_ff.w)) >> 2);
	assign fstart = (foff == '0) ? '0 : 5'({cfg_ff.b, 1'b0} - 5'(foff));
	assign rstart = (roff == '0) ? '0 : 5'({cfg_ff.w, 1'b0} - 5'(roff));
	assign boundary = running_ff && bitcnt_ff == '0 && !half_ff;
	assign bit_start = running_ff && !half_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bitcnt_ff <= '0;
			half_ff <= 1'b0;
		end else if (!running_ff) begin
			bitcnt_ff <= '0;
			half_ff <= 1'b0;
		end else begin
			half_ff <= !half_ff;
			if (half_ff) begin
				bitcnt_ff <= (bitcnt_ff == cfg_ff.j - 4'h1) ? '0 : bitcnt_ff + 4'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fwdcnt_ff <= '0;
			refcnt_ff <= '0;
		end else if (!running_ff) begin
			fwdcnt_ff <= fstart;
			refcnt_ff <= rstart;
		end else begin
			fwdcnt_ff <= (fwdcnt_ff == 5'({cfg_ff.b, 1'b0}) - 5'h01) ? '0 : fwdcnt_ff + 5'h01;
			refcnt_ff <= (refcnt_ff == 5'({cfg_ff.w, 1'b0}) - 5'h01) ? '0 : refcnt_ff + 5'h01;
		end
	end

	// fwd_clk high for the first B of 2B cycles, ref_clk for the first W of 2W; seven by seven has no special case
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fwd_clk <= 1'b0;
			core_clk <= 1'b0;
			ref_clk <= 1'b0;
			tx_locked <= 1'b0;
		end else begin
			fwd_clk <= running_ff && fwdcnt_ff < 5'(cfg_ff.b);
			core_clk <= running_ff && bitcnt_ff < 4'((cfg_ff.j + 4'h1) >> 1);
			ref_clk <= running_ff && refcnt_ff < 5'(cfg_ff.w);
			tx_locked <= running_ff;
		end
	end

	// optional input register, ticking on reference or core rising edge
	assign reg_tick = cfg_ff.reg_clk_core ? boundary : (running_ff && refcnt_ff == '0);
	assign in_ready = cfg_ff.reg_en ? (reg_tick && !stg_vld_ff) : f_in_ready;
	assign f_in_data = cfg_ff.reg_en ? stg_ff : in_data;
	assign f_in_valid = cfg_ff.reg_en ? stg_vld_ff : in_valid;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stg_ff <= '0;
			stg_vld_ff <= 1'b0;
		end else if (cfg_ff.reg_en && in_valid && in_ready) begin
			stg_ff <= in_data;
			stg_vld_ff <= 1'b1;
		end else if (stg_vld_ff && f_in_ready) begin
			stg_vld_ff <= 1'b0;
		end
	end

	ser_tx_fifo #(
		.WIDTH(BUS_W),
		.DEPTH(ser_tx_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(pclk),
		.rst_n(presetn),
		.in_data(f_in_data),
		.in_valid(f_in_valid),
		.in_ready(f_in_ready),
		.out_data(f_out_data),
		.out_valid(f_out_valid),
		.out_ready(boundary),
		.empty(f_empty),
		.full(f_full)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			underrun_ff <= 1'b0;
		end else if (boundary && !f_out_valid) begin
			underrun_ff <= 1'b1;
		end else if (wr_en && paddr == ser_tx_pkg::ADDR_STATUS && pwdata[ser_tx_pkg::ST_UNDERRUN]) begin
			underrun_ff <= 1'b0;
		end
	end

	for (genvar n = 0; n < CHANNELS; n++) begin : g_lane
		logic [JM-1:0] raw;
		assign raw = JM'(f_out_data >> (int'(cfg_ff.j) * n));
		assign lane_word[n] = f_out_valid ? JM'(raw << (4'(JM) - cfg_ff.j)) : '0;

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				shreg_ff[n] <= '0;
				ser_out[n] <= 1'b0;
			end else if (!running_ff) begin
				shreg_ff[n] <= '0;
				ser_out[n] <= 1'b0;
			end else if (boundary) begin
				ser_out[n] <= lane_word[n][JM-1];
				shreg_ff[n] <= JM'(lane_word[n] << 1);
			end else if (bit_start) begin
				ser_out[n] <= shreg_ff[n][JM-1];
				shreg_ff[n] <= JM'(shreg_ff[n] << 1);
			end
		end
	end

	// checking helpers
	logic [5:0] fgap_ff;
	logic [5:0] cgap_ff;
	logic fseen_ff;
	logic cseen_ff;
	logic [JM-1:0] word0;
	assign word0 = lane_word[0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fgap_ff <= '0;
			cgap_ff <= '0;
			fseen_ff <= 1'b0;
			cseen_ff <= 1'b0;
		end else if (!running_ff) begin
			fseen_ff <= 1'b0;
			cseen_ff <= 1'b0;
		end else begin
			fgap_ff <= (fwd_clk == 1'b0 && fwdcnt_ff < 5'(cfg_ff.b)) ? '0 : fgap_ff + 6'h01;
			fseen_ff <= fseen_ff || (!fwd_clk && fwdcnt_ff == '0);
			cgap_ff <= boundary ? '0 : cgap_ff + 6'h01;
			cseen_ff <= cseen_ff || boundary;
		end
	end

	sequence seq_word_load;
		boundary && f_out_valid;
	endsequence

	sequence seq_first_bit(logic b);
		ser_out[0] == b;
	endsequence

	chk_cfg_always_legal: assert property (@(posedge pclk) disable iff (!presetn)
		ser_tx_pkg::cfg_legal(cfg_ff, refk_ff)) else $error("active settings are illegal");
	chk_div_follows_j: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == ser_tx_pkg::ADDR_CFG && !running_ff && !$past(running_ff)
		&& pwdata[7:4] == ser_tx_pkg::B_FOLLOW_J && ser_tx_pkg::cfg_legal(wr_cfg, refk_ff)
		|=> cfg_ff.b == cfg_ff.j) else $error("divide factor did not follow J");
	chk_fwd_period: assert property (@(posedge pclk) disable iff (!presetn)
		running_ff && fseen_ff && !fwd_clk && fwdcnt_ff < 5'(cfg_ff.b)
		|-> fgap_ff == 6'({cfg_ff.b, 1'b0}) - 6'h01) else $error("forwarded clock period wrong");
	chk_core_period: assert property (@(posedge pclk) disable iff (!presetn)
		boundary && cseen_ff |-> cgap_ff == 6'({cfg_ff.j, 1'b0}) - 6'h01)
		else $error("core clock period wrong");
	chk_rate_limits: assert property (@(posedge pclk) disable iff (!presetn)
		running_ff |-> 28'(refk_ff) * 28'(cfg_ff.w) <= ser_tx_pkg::MAX_DATA_KHZ)
		else $error("lane rate above limit");
	chk_center_phase: assert property (@(posedge pclk) disable iff (!presetn)
		boundary && $past(running_ff) && cfg_ff.out_phase == ser_tx_pkg::PH_CENTER
		|=> !fwd_clk ##1 (fwd_clk == (cfg_ff.b == ser_tx_pkg::B_1)))
		else $error("center phase not half period");
	chk_msb_first: assert property (@(posedge pclk) disable iff (!presetn)
		seq_word_load |=> seq_first_bit($past(word0[JM-1])))
		else $error("lane did not start with MSB");
	chk_next_bit: assert property (@(posedge pclk) disable iff (!presetn)
		seq_word_load ##1 running_ff[*2] |=> seq_first_bit($past(word0[JM-2], 3)))
		else $error("second bit not in order");
	chk_enable_stop: assert property (@(posedge pclk) disable iff (!presetn)
		!tx_pll_enable |-> ##[1:2] !tx_locked) else $error("locked stayed up without enable");
	chk_full_stalls: assert property (@(posedge pclk) disable iff (!presetn)
		!cfg_ff.reg_en && f_full |-> !in_ready) else $error("ready high while buffer full");

endmodule

// ==== core/ser_tx_pkg.sv ====
package ser_tx_pkg;

	localparam int J_MAX = 10;
	localparam int FIFO_DEPTH = 8;
	localparam int CFG_W = 20;
	localparam int REFK_W = 20;

	// serialization factors and divide factors share one code space
	localparam logic [3:0] F_4 = 4'h4;
	localparam logic [3:0] F_7 = 4'h7;
	localparam logic [3:0] F_8 = 4'h8;
	localparam logic [3:0] F_10 = 4'hA;
	localparam logic [3:0] B_1 = 4'h1;
	localparam logic [3:0] B_2 = 4'h2;
	localparam logic [3:0] B_FOLLOW_J = 4'h0;

	// phase codes count 45 degree steps
	localparam logic [2:0] PH_EDGE = 3'h0;
	localparam logic [2:0] PH_90 = 3'h2;
	localparam logic [2:0] PH_CENTER = 3'h4;

	localparam logic [27:0] MAX_DATA_KHZ = 28'h00CD140;
	localparam logic [27:0] MAX_FWD_KHZ = 28'h007A120;

	localparam logic [11:0] ADDR_CFG = 12'h000;
	localparam logic [11:0] ADDR_REFK = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;

	localparam int ST_LOCKED = 0;
	localparam int ST_CFG_ERR = 1;
	localparam int ST_UNDERRUN = 2;
	localparam int ST_EMPTY = 3;
	localparam int ST_FULL = 4;

	typedef struct packed {
		logic reg_clk_core;
		logic reg_en;
		logic [2:0] out_phase;
		logic [2:0] in_phase;
		logic [3:0] w;
		logic [3:0] b;
		logic [3:0] j;
	} cfg_t;

	localparam cfg_t CFG_RESET = '{reg_clk_core: 1'b0, reg_en: 1'b0, out_phase: PH_EDGE,
		in_phase: PH_EDGE, w: F_10, b: F_10, j: F_10};
	localparam logic [REFK_W-1:0] REFK_RESET = 20'h0C350;

	function automatic logic factor_ok(input logic [3:0] f);
		return (f == F_4) || (f == F_7) || (f == F_8) || (f == F_10);
	endfunction

	function automatic logic div_ok(input logic [3:0] j, input logic [3:0] b);
		logic ok;
		ok = (b == B_1) || (b == j);
		if (j == F_4 || j == F_8 || j == F_10) begin
			ok = ok || (b == B_2);
		end
		if (j == F_8) begin
			ok = ok || (b == F_4);
		end
		return ok;
	endfunction

	function automatic cfg_t cfg_resolve(input cfg_t c);
		cfg_t r;
		r = c;
		if (c.b == B_FOLLOW_J) begin
			r.b = c.j;
		end
		return r;
	endfunction

	function automatic logic cfg_legal(input cfg_t c, input logic [REFK_W-1:0] refk);
		logic [27:0] rate;
		rate = 28'(refk) * 28'(c.w);
		return factor_ok(c.j) && factor_ok(c.w) && div_ok(c.j, c.b)
			&& (c.in_phase != PH_90) && (c.out_phase != PH_90)
			&& (rate > 28'(refk)) && (rate <= MAX_DATA_KHZ)
			&& (rate <= MAX_FWD_KHZ * 28'(c.b));
	endfunction

endpackage

// ==== test/ser_rx_model.sv ====
`timescale 1ns/1ps

module ser_rx_model #(
	parameter int CHANNELS = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [CHANNELS-1:0] ser_out,
	input wire logic core_clk,
	input wire logic [3:0] j,
	output logic [CHANNELS*ser_tx_pkg::J_MAX-1:0] rx_word,
	output logic rx_stb
);
	logic core_q;
	int cnt;
	logic [9:0] sh [CHANNELS];

	// word starts where core clock rises; two pclk per bit
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_q = 1'b0;
			cnt = 99;
			rx_stb = 1'b0;
			rx_word = '0;
		end else begin
			rx_stb = 1'b0;
			if (core_clk === 1'b1 && core_q === 1'b0) begin
				cnt = 0;
			end
			if (cnt < 2 * int'(j) && cnt % 2 == 0) begin
				for (int n = 0; n < CHANNELS; n++) begin
					sh[n] = {sh[n][8:0], ser_out[n]};
				end
			end
			if (cnt == 2 * int'(j) - 2) begin
				rx_word = '0;
				for (int n = 0; n < CHANNELS; n++) begin
					for (int b = 0; b < int'(j); b++) begin
						rx_word[int'(j) * n + b] = sh[n][b];
					end
				end
				rx_stb = 1'b1;
			end
			if (cnt < 99) begin
				cnt++;
			end
			core_q = core_clk;
		end
	end
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps

module tb_top;
	localparam int CH = 21;
	localparam logic [11:0] A_CFG = ser_tx_pkg::ADDR_CFG;
	localparam logic [11:0] A_REFK = ser_tx_pkg::ADDR_REFK;
	localparam logic [11:0] A_ST = ser_tx_pkg::ADDR_STATUS;
	typedef logic [CH*4-1:0] lane_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_pll_enable;
	logic in_valid, in_ready, fwd_clk, core_clk, ref_clk, tx_locked, rx_stb, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [CH*10-1:0] in_data, rx_word;
	logic [CH-1:0] ser_out;
	lane_t exq[$];
	lane_t rxq[$];
	int err_count, total_checks, n, acc;

	lvds_serializer_transmitter #(.CHANNELS(CH)) u_lvds_serializer_transmitter (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_pll_enable(tx_pll_enable), .in_data(in_data), .in_valid(in_valid),
		.in_ready(in_ready), .ser_out(ser_out), .fwd_clk(fwd_clk), .core_clk(core_clk),
		.ref_clk(ref_clk), .tx_locked(tx_locked));

	ser_rx_model #(.CHANNELS(CH)) u_ser_rx_model (.pclk(pclk), .presetn(presetn),
		.ser_out(ser_out), .core_clk(core_clk), .j(4'h4), .rx_word(rx_word), .rx_stb(rx_stb));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	always @(negedge pclk) begin
		if (rx_stb === 1'b1 && rx_word[CH*4-1:0] != '0) begin
			rxq.push_back(rx_word[CH*4-1:0]);
		end
	end

	task automatic close_out();
		if (err_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input lane_t x, input lane_t y);
		total_checks++;
		if (y !== x) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, x, y);
		end
	endtask

	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic ser_tx_pkg::cfg_t mk(input logic [3:0] j, b, w, input logic [2:0] ph);
		mk = '0;
		mk.j = j;
		mk.b = b;
		mk.w = w;
		mk.in_phase = ph;
	endfunction

	function automatic logic [CH*10-1:0] pat(input int k);
		pat = '1;
		for (int i = 0; i < CH; i++) begin
			pat[4*i+:4] = 4'(k + i + 1);
		end
	endfunction

	task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic ok);
		logic [31:0] x;
		x = d;
		if (a == A_CFG && d[7:4] == 4'h0) begin
			x[7:4] = d[3:0];
		end
		apb(a, 1'b1, d);
		apb(A_ST, 1'b0, 32'h0);
		chk("cfg_err", lane_t'(!ok), lane_t'(r[1]));
		if (ok) begin
			apb(a, 1'b0, 32'h0);
			chk("readback", lane_t'(x), lane_t'(r));
		end
	endtask

	// holds the word until ready is seen, then lets the accepting edge pass
	task automatic push(input int k);
		logic [CH*10-1:0] p;
		int i;
		p = pat(k);
		i = 0;
		@(posedge pclk);
		in_data <= p;
		in_valid <= 1'b1;
		@(negedge pclk);
		while (in_ready !== 1'b1 && i < 200) begin
			@(negedge pclk);
			i++;
		end
		@(posedge pclk);
		in_valid <= 1'b0;
		if (i < 200) begin
			acc++;
			exq.push_back(p[CH*4-1:0]);
		end
	endtask

	// cycles between two rises of the chosen clock output
	task automatic per(input int s, output int cnt);
		logic p, v;
		int rs;
		rs = 0;
		cnt = 0;
		p = 1'b1;
		for (int i = 0; i < 100 && rs < 2; i++) begin
			@(negedge pclk);
			v = (s == 0) ? fwd_clk : ((s == 1) ? core_clk : ref_clk);
			if (v === 1'b1 && p === 1'b0) rs++;
			if (rs == 1) cnt++;
			p = v;
		end
	endtask

	initial begin
		#(50 * 20000);
		err_count++;
		$display("ERROR watchdog expected done seen timeout");
		close_out();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		tx_pll_enable = 1'b0;
		in_valid = 1'b0;
		in_data = '0;
		err_count = 0;
		total_checks = 0;
		acc = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(A_CFG, 1'b0, 32'h0);
		chk("cfg_reset", lane_t'(32'h00000AAA), lane_t'(r));
		apb(A_REFK, 1'b0, 32'h0);
		chk("refk_reset", lane_t'(32'h0000C350), lane_t'(r));
		apb(A_ST, 1'b0, 32'h0);
		chk("status_reset", lane_t'(32'h00000008), lane_t'(r));
		apb(12'h00C, 1'b0, 32'h0);
		chk("unmapped_err", lane_t'(1'b1), lane_t'(e));
		chk("unmapped_data", lane_t'(0), lane_t'(r));
		wr_chk(A_CFG, 32'(mk(4'h5, 4'h5, 4'hA, 3'h0)), 1'b0);
		wr_chk(A_CFG, 32'(mk(4'h7, 4'h2, 4'h7, 3'h0)), 1'b0);
		wr_chk(A_CFG, 32'(mk(4'h8, 4'h4, 4'h8, 3'h0)), 1'b1);
		wr_chk(A_CFG, 32'(mk(4'h7, 4'h7, 4'h7, 3'h0)), 1'b1);
		wr_chk(A_CFG, 32'(mk(4'h4, 4'h0, 4'h4, 3'h0)), 1'b1);
		wr_chk(A_CFG, 32'(mk(4'h4, 4'h4, 4'h5, 3'h0)), 1'b0);
		wr_chk(A_CFG, 32'(mk(4'h4, 4'h4, 4'h4, 3'h2)), 1'b0);
		wr_chk(A_CFG, 32'(mk(4'h4, 4'h4, 4'h4, 3'h4)), 1'b1);
		wr_chk(A_CFG, 32'(mk(4'hA, 4'h1, 4'hA, 3'h0)), 1'b1);
		wr_chk(A_REFK, 32'h00015F90, 1'b0);
		wr_chk(A_REFK, 32'h00013880, 1'b0);
		wr_chk(A_CFG, 32'(mk(4'hA, 4'h2, 4'hA, 3'h0)), 1'b1);
		wr_chk(A_REFK, 32'h00013880, 1'b1);
		wr_chk(A_REFK, 32'h0000C350, 1'b1);
		wr_chk(A_CFG, 32'(mk(4'h4, 4'h2, 4'h4, 3'h0)), 1'b1);
		for (int k = 0; k < ser_tx_pkg::FIFO_DEPTH; k++) push(k);
		chk("accepted", lane_t'(ser_tx_pkg::FIFO_DEPTH), lane_t'(acc));
		@(negedge pclk);
		chk("full_ready", lane_t'(0), lane_t'(in_ready));
		apb(A_ST, 1'b0, 32'h0);
		chk("full_empty", lane_t'(2'b10), lane_t'(r[4:3]));
		@(posedge pclk);
		tx_pll_enable <= 1'b1;
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		chk("locked", lane_t'(1'b1), lane_t'(tx_locked));
		chk("edge_fwd", lane_t'(1), lane_t'(fwd_clk));
		per(0, n);
		chk("fwd_period", lane_t'(4), lane_t'(n));
		per(1, n);
		chk("core_period", lane_t'(8), lane_t'(n));
		per(2, n);
		chk("ref_period", lane_t'(8), lane_t'(n));
		for (int i = 0; i < 400 && rxq.size() < 8; i++) @(posedge pclk);
		chk("words", lane_t'(8), lane_t'(rxq.size()));
		foreach (exq[i]) begin
			if (i < rxq.size()) chk("lanes", exq[i], rxq[i]);
		end
		apb(A_ST, 1'b0, 32'h0);
		chk("status_run", lane_t'(32'h0000000D), lane_t'(r));
		wr_chk(A_CFG, 32'(mk(4'hA, 4'hA, 4'hA, 3'h0)), 1'b0);
		@(posedge pclk);
		tx_pll_enable <= 1'b0;
		repeat (4) @(posedge pclk);
		apb(A_ST, 1'b1, 32'h00000004);
		apb(A_ST, 1'b0, 32'h0);
		chk("underrun_clear", lane_t'(0), lane_t'({r[2], r[0]}));
		// second run: center output phase, input stage on core ticks
		wr_chk(A_CFG, 32'(mk(4'h4, 4'h2, 4'h4, 3'h0)) | 32'h000E0000, 1'b1);
		exq.delete();
		rxq.delete();
		acc = 0;
		@(posedge pclk);
		tx_pll_enable <= 1'b1;
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		chk("center_fwd", lane_t'(0), lane_t'(fwd_clk));
		for (int k = 10; k < 14; k++) push(k);
		chk("staged", lane_t'(4), lane_t'(acc));
		for (int i = 0; i < 400 && rxq.size() < 4; i++) @(posedge pclk);
		chk("staged_words", lane_t'(4), lane_t'(rxq.size()));
		foreach (exq[i]) begin
			if (i < rxq.size()) chk("staged_lanes", exq[i], rxq[i]);
		end
		close_out();
	end
endmodule
